// ==== hdl/bdbr_top.sv ====
/*
 * Background debug breakpoint, failure status and force-reset registers.
 * Assumes the serial command decoder outside delivers one-cycle command
 * strobes with data on mclk, and CPU status arrives from other clock logic
 * or pins through the synchronisers here.
 */
`timescale 1ns/1ps
`include "bdbr_map.svh"

module bdbr_top
    import bdbr_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    // serial command side
    input wire logic bkpt_wr_cmd,
    input wire logic bkpt_rd_cmd,
    input wire logic [15:0] bkpt_wdata,
    output logic [15:0] bkpt_rdata,
    input wire logic sc_wr_cmd,
    input wire logic [7:0] sc_wdata,
    output logic [7:0] sc_rdata,
    input wire logic ser_byte_wr,
    input wire logic [7:0] ser_byte_addr,
    input wire logic [7:0] ser_byte_wdata,
    input wire logic ser_byte_rd,
    output logic [7:0] ser_byte_rdata,
    // user program bus
    input wire logic user_wr,
    input wire logic [7:0] user_addr,
    input wire logic [7:0] user_wdata,
    // cpu status, from outside this clock domain
    input wire logic cpu_wait_stop,
    input wire logic bgnd_from_ws,
    input wire logic mem_cmd_fail_ws,
    input wire logic mem_cmd_fail_slow,
    input wire logic mem_cmd_start,
    // cpu address and fetch, same clock
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_opcode_fetch,
    output logic bkpt_force_req,
    output logic bkpt_tag_opcode,
    output logic mcu_rst_req
);
    // ------------------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------------------
    // one two-stage chain per status line; only stage two feeds logic,
    // so a metastable first stage never reaches the flags
    logic [4:0] async_in;
    wire logic [4:0] sync_s;
    assign async_in = {mem_cmd_start, mem_cmd_fail_slow, mem_cmd_fail_ws,
                       bgnd_from_ws, cpu_wait_stop};

    for (genvar gi = 0; gi < 5; gi++) begin : g_sync
        logic stage1_r;
        logic stage2_r;
        always_ff @(posedge mclk) begin
            if (!nrst) begin
                stage1_r <= 1'b0;
                stage2_r <= 1'b0;
            end else begin
                stage1_r <= async_in[gi];
                stage2_r <= stage1_r;
            end
        end
        assign sync_s[gi] = stage2_r;
    end

    logic ws_s, bgws_s, fail_ws_s, fail_slow_s, start_s;
    assign {start_s, fail_slow_s, fail_ws_s, bgws_s, ws_s} = sync_s;

    // ------------------------------------------------------------------------
    // status and control
    // ------------------------------------------------------------------------
    logic bkpt_en_r, fts_r, wsf_r, dvf_r;
    logic [7:0] bkpt_hi_r, bkpt_lo_r;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bkpt_en_r <= 1'(`BDBR_SC_RESET >> `BDBR_SC_BREAKPOINT_ENABLE_BIT);
            fts_r <= 1'(`BDBR_SC_RESET >> `BDBR_SC_FTS_BIT);
        end else if (sc_wr_cmd) begin
            bkpt_en_r <= sc_wdata[`BDBR_SC_BREAKPOINT_ENABLE_BIT];
            fts_r <= sc_wdata[`BDBR_SC_FTS_BIT];
        end
    end

    // failure flags hold until the next memory command starts; a failure in
    // the same cycle as the start wins so no event is lost
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wsf_r <= 1'b0;
            dvf_r <= 1'b0;
        end else begin
            if (fail_ws_s) begin
                wsf_r <= 1'b1;
            end else if (start_s) begin
                wsf_r <= 1'b0;
            end
            if (fail_slow_s) begin
                dvf_r <= 1'b1;
            end else if (start_s) begin
                dvf_r <= 1'b0;
            end
        end
    end

    logic ws_bit;
    assign ws_bit = ws_s | bgws_s;

    // read image of status/control; bits outside the five fields read as zero
    function automatic bdbr_byte_t sc_pack(input logic en, input logic force_tag_select, input logic ws,
                                           input logic wait_stop_fail_flag, input logic data_valid_fail_flag);
        bdbr_byte_t v;
        v = 8'h00;
        v[`BDBR_SC_BREAKPOINT_ENABLE_BIT] = en;
        v[`BDBR_SC_FTS_BIT] = force_tag_select;
        v[`BDBR_SC_WS_BIT] = ws;
        v[`BDBR_SC_WSF_BIT] = wait_stop_fail_flag;
        v[`BDBR_SC_DVF_BIT] = data_valid_fail_flag;
        return v;
    endfunction

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sc_rdata <= `BDBR_SC_RESET;
        end else begin
            sc_rdata <= sc_pack(bkpt_en_r, fts_r, ws_bit, wsf_r, dvf_r);
        end
    end

    // ------------------------------------------------------------------------
    // breakpoint address, serial commands only
    // ------------------------------------------------------------------------
    // no user decode exists for these bytes, so user writes cannot reach them
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bkpt_hi_r <= `BDBR_BKPT_RESET;
        end else if (bkpt_wr_cmd) begin
            bkpt_hi_r <= bkpt_wdata[15:8];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bkpt_lo_r <= `BDBR_BKPT_RESET;
        end else if (bkpt_wr_cmd) begin
            bkpt_lo_r <= bkpt_wdata[7:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bkpt_rdata <= 16'h0000;
        end else if (bkpt_rd_cmd) begin
            bkpt_rdata <= {bkpt_hi_r, bkpt_lo_r};
        end
    end

    // ------------------------------------------------------------------------
    // breakpoint comparison
    // ------------------------------------------------------------------------
    function automatic logic addr_hit(input logic [15:0] a, input logic [7:0] hi,
                                      input logic [7:0] lo);
        addr_hit = (a == {hi, lo});
    endfunction

    // force mode fires on any matching address, even a data access; tag mode
    // only marks a matching fetch and leaves the execute decision to the core
    logic hit;
    assign hit = bkpt_en_r && addr_hit(cpu_addr, bkpt_hi_r, bkpt_lo_r);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            bkpt_force_req <= 1'b0;
            bkpt_tag_opcode <= 1'b0;
        end else begin
            bkpt_force_req <= hit && fts_r;
            bkpt_tag_opcode <= hit && !fts_r && cpu_opcode_fetch;
        end
    end

    // ------------------------------------------------------------------------
    // force-reset register
    // ------------------------------------------------------------------------
    // the pulse generator refuses new requests until it is idle again
    logic frc_req;
    // user_wr/user_addr/user_wdata deliberately take no part: user writes ignored
    assign frc_req = ser_byte_wr && (ser_byte_addr == `BDBR_FRC_RST_OFS)
                     && ser_byte_wdata[`BDBR_FRC_RST_BIT];

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ser_byte_rdata <= 8'h00;
        end else if (ser_byte_rd) begin
            ser_byte_rdata <= `BDBR_FRC_RST_READ;
        end
    end

    bdbr_rst_gen u_rst (
        .mclk(mclk),
        .nrst(nrst),
        .req(frc_req),
        .mcu_rst_req(mcu_rst_req)
    );
endmodule

// ==== hdl/bdbr_map.svh ====
/*
 * Constants for the debug breakpoint and force-reset block: field positions,
 * register offsets, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef BDBR_MAP_SVH
`define BDBR_MAP_SVH

// ----------------------------------------------------------------------------
// status/control field positions
// ----------------------------------------------------------------------------
`define BDBR_SC_DVF_BIT 0
`define BDBR_SC_WSF_BIT 1
`define BDBR_SC_WS_BIT 2
`define BDBR_SC_FTS_BIT 4
`define BDBR_SC_BREAKPOINT_ENABLE_BIT 5

// ----------------------------------------------------------------------------
// register offsets and values
// ----------------------------------------------------------------------------
`define BDBR_FRC_RST_OFS 8'h03
`define BDBR_FRC_RST_BIT 0
`define BDBR_FRC_RST_READ 8'h00
`define BDBR_SC_RESET 8'h00
`define BDBR_BKPT_RESET 8'h00

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define BDBR_CLK_NS 20
`define BDBR_RST_PULSE_NS 100
`define BDBR_RST_PULSE_CYC ((`BDBR_RST_PULSE_NS + `BDBR_CLK_NS - 1) / `BDBR_CLK_NS)

`endif

// ==== hdl/bdbr_pkg.sv ====
/*
 * Types shared by the debug breakpoint and force-reset block.
 * Assumes the map header is found on the include path.
 */
package bdbr_pkg;
    `include "bdbr_map.svh"

    typedef enum logic [2:0] {
        BDBR_IDLE = 3'b001,
        BDBR_PULSE = 3'b010,
        BDBR_DONE = 3'b100
    } bdbr_rst_e;

    typedef logic [7:0] bdbr_byte_t;
endpackage

// ==== hdl/bdbr_rst_gen.sv ====
/*
 * Force-reset pulse generator: one request gives a fixed-length reset pulse.
 * Assumes the request is a one-cycle pulse on mclk.
 */
`timescale 1ns/1ps
`include "bdbr_map.svh"

module bdbr_rst_gen
    import bdbr_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic req,
    output logic mcu_rst_req
);
    localparam logic [3:0] PULSE_LAST = 4'(`BDBR_RST_PULSE_CYC - 1);

    bdbr_rst_e state_r;
    logic [3:0] cnt_r;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= BDBR_IDLE;
            cnt_r <= 4'h0;
        end else begin
            case (state_r)
                BDBR_IDLE: begin
                    cnt_r <= 4'h0;
                    if (req) begin
                        state_r <= BDBR_PULSE;
                    end
                end
                BDBR_PULSE: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == PULSE_LAST) begin
                        state_r <= BDBR_DONE;
                    end
                end
                BDBR_DONE: begin
                    state_r <= BDBR_IDLE;
                end
                default: begin
                    state_r <= BDBR_IDLE;
                end
            endcase
        end
    end

    // reset of the whole mcu normally clears nrst here too; the pulse is self-ending anyway
    assign mcu_rst_req = (state_r == BDBR_PULSE);
endmodule

// ==== test/bdbr_assertions.sv ====
/* Port checker for bdbr_top.
   Assumes binding by name to bdbr_top; single mclk domain, sync nrst. */
`timescale 1ns/1ps
module bdbr_assertions (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic bkpt_wr_cmd,
    input wire logic bkpt_rd_cmd,
    input wire logic [15:0] bkpt_wdata,
    input wire logic [15:0] bkpt_rdata,
    input wire logic [7:0] sc_rdata,
    input wire logic ser_byte_wr,
    input wire logic [7:0] ser_byte_addr,
    input wire logic [7:0] ser_byte_wdata,
    input wire logic ser_byte_rd,
    input wire logic [7:0] ser_byte_rdata,
    input wire logic user_wr,
    input wire logic cpu_wait_stop,
    input wire logic mem_cmd_fail_ws,
    input wire logic mem_cmd_fail_slow,
    input wire logic cpu_opcode_fetch,
    input wire logic bkpt_force_req,
    input wire logic bkpt_tag_opcode,
    input wire logic mcu_rst_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // a request in the BDBR_DONE cycle straight after a pulse is refused
    rst_len_a: assert property (ser_byte_wr && ser_byte_addr == 8'h03
        && ser_byte_wdata[0] && !mcu_rst_req && !$past(mcu_rst_req)
        |=> mcu_rst_req[*5] ##1 !mcu_rst_req)
        else $error("force reset pulse wrong");
    user_ign_a: assert property (user_wr && !ser_byte_wr && !mcu_rst_req
        |=> !mcu_rst_req) else $error("user write reset");
    rd_zero_a: assert property (ser_byte_rd |=> ser_byte_rdata == 8'h00)
        else $error("force reset read not zero");
    bkpt_rt_a: assert property (bkpt_wr_cmd ##1 (bkpt_rd_cmd && !bkpt_wr_cmd)
        |=> bkpt_rdata == $past(bkpt_wdata, 2)) else $error("breakpoint readback");
    rd_hold_a: assert property (!bkpt_rd_cmd |=> $stable(bkpt_rdata))
        else $error("breakpoint read data moved");
    force_en_a: assert property (bkpt_force_req |-> sc_rdata[5] && sc_rdata[4])
        else $error("force without enable");
    tag_en_a: assert property (bkpt_tag_opcode |-> sc_rdata[5] && !sc_rdata[4]
        && $past(cpu_opcode_fetch)) else $error("tag without fetch");
    ws_set_a: assert property (cpu_wait_stop[*6] |-> sc_rdata[2])
        else $error("wait stop status");
    wsf_set_a: assert property (mem_cmd_fail_ws[*6] |-> sc_rdata[1])
        else $error("wait stop fail flag");
    dvf_set_a: assert property (mem_cmd_fail_slow[*6] |-> sc_rdata[0])
        else $error("data valid fail flag");
endmodule
bind bdbr_top bdbr_assertions bdbr_assertions_i (.*);

// ==== test/bdbr_host.sv ====
/* Debug host model driving serial command strobes.
   Assumes calls at a falling edge; one strobe vector write per call. */
`timescale 1ns/1ps
module bdbr_host (
    input wire logic mclk,
    output logic bkpt_wr_cmd,
    output logic bkpt_rd_cmd,
    output logic [15:0] bkpt_wdata,
    output logic sc_wr_cmd,
    output logic [7:0] sc_wdata,
    output logic ser_byte_wr,
    output logic [7:0] ser_byte_addr,
    output logic [7:0] ser_byte_wdata,
    output logic ser_byte_rd
);
    initial {ser_byte_rd, ser_byte_wr, sc_wr_cmd, bkpt_rd_cmd, bkpt_wr_cmd} = 5'h00;
    initial {bkpt_wdata, sc_wdata, ser_byte_addr, ser_byte_wdata} = '0;
    // k: 0 bkpt write, 1 bkpt read, 2 status write, 3 byte write, 4 byte read, 5 idle
    task automatic cmd(input int k, input logic [15:0] d, input logic [7:0] a);
        {ser_byte_rd, ser_byte_wr, sc_wr_cmd, bkpt_rd_cmd, bkpt_wr_cmd} = 5'h01 << k;
        // released data lines flip so stale values never look valid
        {bkpt_wdata, sc_wdata, ser_byte_addr, ser_byte_wdata} = (k == 5) ?
            ~{bkpt_wdata, sc_wdata, ser_byte_addr, ser_byte_wdata} : {d, d[7:0], a, d[7:0]};
        @(negedge mclk);
    endtask
endmodule

// ==== test/bdbr_top_test.sv ====
/* Self-checking bench for bdbr_top with the host model.
   Assumes 50 MHz mclk; bench drives inputs on falling edges. */
`timescale 1ns/1ps
module bdbr_top_test;
    logic mclk = 1'b0, nrst = 1'b0, user_wr = 1'b0, cpu_wait_stop = 1'b0, bgnd_from_ws = 1'b0;
    logic mem_cmd_fail_ws = 1'b0, mem_cmd_fail_slow = 1'b0, mem_cmd_start = 1'b0;
    logic cpu_opcode_fetch = 1'b0, bkpt_wr_cmd, bkpt_rd_cmd, sc_wr_cmd, ser_byte_wr;
    logic ser_byte_rd, bkpt_force_req, bkpt_tag_opcode, mcu_rst_req;
    logic [7:0] user_addr = 8'h00, user_wdata = 8'h00, sc_wdata, sc_rdata;
    logic [7:0] ser_byte_addr, ser_byte_wdata, ser_byte_rdata;
    logic [15:0] cpu_addr = 16'h0000, bkpt_wdata, bkpt_rdata, bk;
    logic [31:0] seed = 32'hA9AFBCEB;
    int err_total = 0, comparisons = 0, cyc = 0;
    // model of the breakpoint word: newest entry is what a read must return
    int bkpt_q[$];
    bdbr_top bdbr_top_i (.*);
    bdbr_host bdbr_host_i (.*);
    initial forever #10 mclk = ~mclk;
    // ceiling well above the roughly 70 cycles the tests take
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            results();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rst();
        nrst = 1'b0;
        repeat (5) @(negedge mclk);
        nrst = 1'b1;
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst();
        bkpt_q.push_back(0);
        bdbr_host_i.cmd(1, 16'h0000, 8'h00);
        chk(bkpt_rdata, 16'(bkpt_q[$]));
        chk(sc_rdata, 8'h00);
        repeat (4) begin
            seed = lfsr(seed);
            bk = seed[15:0];
            cpu_addr = seed[31:16];
            bdbr_host_i.cmd(0, bk, 8'h00);
            bkpt_q.push_back(int'(bk));
            bdbr_host_i.cmd(1, 16'h0000, 8'h00);
            chk(bkpt_rdata, 16'(bkpt_q[$]));
        end
        $display("test breakpoint access done");
        for (int m = 0; m < 4; m++) begin
            bdbr_host_i.cmd(2, 16'(m << 4), 8'h00);
            bdbr_host_i.cmd(5, 16'h0000, 8'h00);
            chk(sc_rdata & 8'h30, 16'(m << 4));
            cpu_opcode_fetch = 1'b1;
            cpu_addr = bk;
            @(negedge mclk);
            chk({bkpt_force_req, bkpt_tag_opcode}, {m[1] & m[0], m[1] & ~m[0]});
            cpu_addr = ~bk;
            @(negedge mclk);
            chk({bkpt_force_req, bkpt_tag_opcode}, 2'b00);
            cpu_opcode_fetch = 1'b0;
        end
        $display("test breakpoint modes done");
        {cpu_wait_stop, mem_cmd_fail_ws, mem_cmd_fail_slow} = 3'b111;
        repeat (6) @(negedge mclk);
        chk(sc_rdata & 8'h07, 8'h07);
        {cpu_wait_stop, mem_cmd_fail_ws, mem_cmd_fail_slow, bgnd_from_ws} = 4'b0001;
        repeat (6) @(negedge mclk);
        chk(sc_rdata & 8'h07, 8'h07);
        bdbr_host_i.cmd(1, 16'h0000, 8'h00);
        bdbr_host_i.cmd(5, 16'h0000, 8'h00);
        {mem_cmd_start, bgnd_from_ws} = 2'b10;
        repeat (6) @(negedge mclk);
        chk(sc_rdata & 8'h07, 8'h00);
        {mem_cmd_start, mem_cmd_fail_slow} = 2'b01;
        repeat (6) @(negedge mclk);
        chk(sc_rdata & 8'h07, 8'h01);
        $display("test status flags done");
        {user_wr, user_addr, user_wdata} = {1'b1, 8'h03, 8'hFF};
        @(negedge mclk);
        user_wr = 1'b0;
        @(negedge mclk);
        chk(mcu_rst_req, 1'b0);
        bdbr_host_i.cmd(4, 16'h0000, 8'h03);
        chk(ser_byte_rdata, 8'h00);
        bdbr_host_i.cmd(3, 16'h0001, 8'h03);
        chk(mcu_rst_req, 1'b1);
        bdbr_host_i.cmd(5, 16'h0000, 8'h00);
        repeat (4) begin
            chk(mcu_rst_req, 1'b1);
            @(negedge mclk);
        end
        chk(mcu_rst_req, 1'b0);
        rst();
        bkpt_q.push_back(0);
        bdbr_host_i.cmd(1, 16'h0000, 8'h00);
        chk(bkpt_rdata, 16'(bkpt_q[$]));
        $display("test force reset done");
        results();
    end
endmodule
